/* File: rtl/afe_digital_control.sv */
// digitiser control: serial register port, code conditioning and output multiplexer
`timescale 1ns/1ps
// How it works
// - black select 10 adds full scale, 11 adds zero, 00/01 add mid-range
// - conversion result is a 16-bit unsigned code before polarity change
// - invert bit set outputs 65535 minus code, else code passes unchanged
// - format 00/01/10 sends high then low byte; 11 sends nibbles on upper lines
// - nibble order is bits 15-12, 11-8, 7-4, then 3-0
// - two-bit latency field delays output words relative to pixel sync
// - frame is six address then eight data bits, MSB first, on serial clock rise
// - latch strobe transfers shifted data into the addressed register
// - write frames keep address bit a4 low
// - write to address 000100 resets all registers to defaults
// - a4 set requests read-back of register a4-clear, MSB first on falling edges
// - next frame may shift in while read-back word still shifts out
// - sample taken on first master clock rise after pixel sync falls
// - edge detect mode makes internal pulse from selected sync pin edge
// - internal pulse delayed by three-bit count of master clock periods
// - internal pulse replaces pin pulse; sample on next master clock rise
module afe_digital_control (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_serial_clk,
	input wire logic i_serial_in,
	input wire logic i_serial_latch_strobe,
	input wire logic i_pixel_sync_pulse,
	input wire logic i_master_clk,
	input wire logic i_output_enable_n,
	input wire logic signed [afe_pkg::RAW_W-1:0] i_adc_raw,
	output logic [7:0] o_pixel_out_bus,
	output logic o_pixel_out_oe,
	output logic o_sample_strobe,
	output afe_pkg::afe_cfg_s o_cfg
);

	// ==========================================================
	// pin synchronisers
	logic [afe_pkg::PIN_N-1:0] pin_raw;
	logic [afe_pkg::PIN_N-1:0] pin_lvl;
	logic [afe_pkg::PIN_N-1:0] pin_rise;
	logic [afe_pkg::PIN_N-1:0] pin_fall;

	assign pin_raw[afe_pkg::PIN_SCK] = i_serial_clk;
	assign pin_raw[afe_pkg::PIN_SDI] = i_serial_in;
	assign pin_raw[afe_pkg::PIN_SEN] = i_serial_latch_strobe;
	assign pin_raw[afe_pkg::PIN_PIXEL_SYNC_PULSE] = i_pixel_sync_pulse;
	assign pin_raw[afe_pkg::PIN_MCLK] = i_master_clk;
	assign pin_raw[afe_pkg::PIN_OEN] = i_output_enable_n;

	genvar gi;
	generate
		for (gi = 0; gi < afe_pkg::PIN_N; gi++) begin : g_pin
			afe_pin_sync u_sync (
				.i_ref_clk(i_ref_clk),
				.i_rst_b(i_rst_b),
				.i_pin(pin_raw[gi]),
				.o_level(pin_lvl[gi]),
				.o_rise(pin_rise[gi]),
				.o_fall(pin_fall[gi])
			);
		end
	endgenerate

	logic sck_rise;
	logic sck_fall;
	logic sen_rise;
	logic mclk_rise;

	assign sck_rise = pin_rise[afe_pkg::PIN_SCK];
	assign sck_fall = pin_fall[afe_pkg::PIN_SCK];
	assign sen_rise = pin_rise[afe_pkg::PIN_SEN];
	assign mclk_rise = pin_rise[afe_pkg::PIN_MCLK];

	// ==========================================================
	// serial shift-in
	logic [afe_pkg::FRAME_W-1:0] shift_q;
	logic [afe_pkg::ADDR_W-1:0] frame_addr;
	logic [afe_pkg::DATA_W-1:0] frame_data;
	logic [afe_pkg::ADDR_W-1:0] reg_addr;
	logic frame_read;
	logic do_write;
	logic do_reset;
	logic do_read;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shift_q <= '0;
		end else if (sck_rise) begin
			shift_q <= {shift_q[afe_pkg::FRAME_W-2:0], pin_lvl[afe_pkg::PIN_SDI]};
		end
	end

	assign frame_addr = shift_q[afe_pkg::FRAME_W-1:afe_pkg::DATA_W];
	assign frame_data = shift_q[afe_pkg::DATA_W-1:0];
	assign frame_read = frame_addr[afe_pkg::READ_BIT];
	always_comb begin
		reg_addr = frame_addr;
		reg_addr[afe_pkg::READ_BIT] = 1'b0;
	end
	assign do_write = sen_rise & ~frame_read;
	assign do_reset = do_write & (frame_addr == afe_pkg::ADDR_SOFT_RESET);
	assign do_read = sen_rise & frame_read;

	// ==========================================================
	// control registers
	logic [afe_pkg::DATA_W-1:0] fmt_q;
	logic [afe_pkg::DATA_W-1:0] syn_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fmt_q <= afe_pkg::FORMAT_RESET;
			syn_q <= afe_pkg::SYNC_RESET;
		end else if (do_reset) begin
			fmt_q <= afe_pkg::FORMAT_RESET;
			syn_q <= afe_pkg::SYNC_RESET;
		end else if (do_write) begin
			if (frame_addr == afe_pkg::ADDR_FORMAT) begin
				fmt_q <= frame_data;
			end else if (frame_addr == afe_pkg::ADDR_SYNC) begin
				syn_q <= frame_data;
			end
		end
	end

	afe_pkg::afe_cfg_s cfg;

	always_comb begin
		cfg.adc_black_level_sel = fmt_q[afe_pkg::FMT_BLACK_LSB +: 2];
		cfg.output_invert = fmt_q[afe_pkg::FMT_INVERT_BIT];
		cfg.output_format_sel = fmt_q[afe_pkg::FMT_FORMAT_LSB +: 2];
		cfg.output_latency_sel = fmt_q[afe_pkg::FMT_LATENCY_LSB +: 2];
		cfg.sync_edge_detect_en = syn_q[afe_pkg::SYN_DETECT_BIT];
		cfg.sync_edge_polarity = syn_q[afe_pkg::SYN_POL_BIT];
		cfg.sync_lag_count = syn_q[afe_pkg::SYN_LAG_LSB +: 3];
	end

	assign o_cfg = cfg;

	// ==========================================================
	// read-back shifter, runs alongside shift-in
	logic [afe_pkg::DATA_W-1:0] rb_q;
	logic [afe_pkg::RB_CNT_W-1:0] rb_cnt_q;
	logic rb_active;
	logic [afe_pkg::DATA_W-1:0] rb_value;

	always_comb begin
		if (reg_addr == afe_pkg::ADDR_FORMAT) begin
			rb_value = fmt_q;
		end else if (reg_addr == afe_pkg::ADDR_SYNC) begin
			rb_value = syn_q;
		end else begin
			rb_value = '0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rb_q <= '0;
			rb_cnt_q <= '0;
		end else if (do_read) begin
			rb_q <= rb_value;
			rb_cnt_q <= afe_pkg::RB_BITS;
		end else if (sck_fall && rb_cnt_q != '0) begin
			rb_q <= {rb_q[afe_pkg::DATA_W-2:0], 1'b0};
			rb_cnt_q <= rb_cnt_q - 4'h1;
		end
	end

	assign rb_active = (rb_cnt_q != '0);

	// ==========================================================
	// sampling strobe
	logic sample;

	afe_sync_gen u_sync_gen (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_mclk_rise(mclk_rise),
		.i_pixel_sync_pulse_rise(pin_rise[afe_pkg::PIN_PIXEL_SYNC_PULSE]),
		.i_pixel_sync_pulse_fall(pin_fall[afe_pkg::PIN_PIXEL_SYNC_PULSE]),
		.i_detect_en(cfg.sync_edge_detect_en),
		.i_polarity(cfg.sync_edge_polarity),
		.i_lag(cfg.sync_lag_count),
		.o_sample(sample)
	);

	assign o_sample_strobe = sample;

	// ==========================================================
	// code conditioning: black level, saturation, invert
	localparam int SUM_W = afe_pkg::SUM_W;
	logic [afe_pkg::CODE_W-1:0] black_off;
	logic signed [afe_pkg::SUM_W-1:0] sum;
	logic [afe_pkg::CODE_W-1:0] code_d1;
	logic [afe_pkg::CODE_W-1:0] code_d2;

	always_comb begin
		if (cfg.adc_black_level_sel == afe_pkg::BLACK_SEL_FULL) begin
			black_off = afe_pkg::BLACK_FULL;
		end else if (cfg.adc_black_level_sel == afe_pkg::BLACK_SEL_ZERO) begin
			black_off = afe_pkg::BLACK_ZERO;
		end else begin
			black_off = afe_pkg::BLACK_MID;
		end
	end

	assign sum = SUM_W'(i_adc_raw) + $signed({3'h0, black_off});

	always_comb begin
		if (sum < 0) begin
			code_d1 = '0;
		end else if (sum > $signed({3'h0, afe_pkg::CODE_MAX})) begin
			code_d1 = afe_pkg::CODE_MAX;
		end else begin
			code_d1 = sum[afe_pkg::CODE_W-1:0];
		end
	end

	assign code_d2 = cfg.output_invert ? (afe_pkg::CODE_MAX - code_d1) : code_d1;

	// ==========================================================
	// latency pipeline in sample periods
	logic [afe_pkg::CODE_W-1:0] lat_q [afe_pkg::LAT_DEPTH];
	logic [afe_pkg::CODE_W-1:0] lat_word;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int k = 0; k < afe_pkg::LAT_DEPTH; k++) begin
				lat_q[k] <= '0;
			end
		end else if (sample) begin
			lat_q[0] <= code_d2;
			for (int k = 1; k < afe_pkg::LAT_DEPTH; k++) begin
				lat_q[k] <= lat_q[k-1];
			end
		end
	end

	always_comb begin
		if (cfg.output_latency_sel == 2'h0) begin
			lat_word = code_d2;
		end else begin
			lat_word = lat_q[cfg.output_latency_sel - 2'h1];
		end
	end

	// ==========================================================
	// output word multiplexer
	logic [afe_pkg::CODE_W-1:0] word_q;
	afe_pkg::afe_phase_e phase_q;
	logic nibble;
	logic [7:0] bus_d;

	assign nibble = (cfg.output_format_sel == afe_pkg::FORMAT_NIBBLE);

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			word_q <= '0;
			phase_q <= afe_pkg::PH_A;
		end else if (sample) begin
			word_q <= lat_word;
			phase_q <= afe_pkg::PH_A;
		end else if (mclk_rise) begin
			case (phase_q)
				afe_pkg::PH_A: begin
					phase_q <= afe_pkg::PH_B;
				end
				afe_pkg::PH_B: begin
					phase_q <= nibble ? afe_pkg::PH_C : afe_pkg::PH_B;
				end
				afe_pkg::PH_C: begin
					phase_q <= afe_pkg::PH_D;
				end
				default: begin
					phase_q <= afe_pkg::PH_D;
				end
			endcase
		end
	end

	always_comb begin
		bus_d = '0;
		if (nibble) begin
			case (phase_q)
				afe_pkg::PH_A: bus_d[7:4] = word_q[15:12];
				afe_pkg::PH_B: bus_d[7:4] = word_q[11:8];
				afe_pkg::PH_C: bus_d[7:4] = word_q[7:4];
				default: bus_d[7:4] = word_q[3:0];
			endcase
		end else if (phase_q == afe_pkg::PH_A) begin
			bus_d = word_q[15:8];
		end else begin
			bus_d = word_q[7:0];
		end
		if (rb_active) begin
			bus_d[7] = rb_q[afe_pkg::DATA_W-1];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pixel_out_bus <= '0;
			o_pixel_out_oe <= 1'b0;
		end else begin
			o_pixel_out_bus <= bus_d;
			o_pixel_out_oe <= ~pin_lvl[afe_pkg::PIN_OEN];
		end
	end

endmodule

/* File: rtl/afe_pin_sync.sv */
// two-flop synchroniser with edge detection for one external pin
`timescale 1ns/1ps
module afe_pin_sync (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_pin,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);

	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign o_level = sync_q;
	assign o_rise = sync_q & ~last_q;
	assign o_fall = ~sync_q & last_q;

endmodule

/* File: rtl/afe_pkg.sv */
// package: constants, register map and carrier types for the digitiser control block
package afe_pkg;

	// ==========================================================
	// serial frame layout
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int FRAME_W = ADDR_W + DATA_W;
	localparam int READ_BIT = 4;
	localparam int RB_CNT_W = 4;
	localparam logic [RB_CNT_W-1:0] RB_BITS = 4'h8;

	// ==========================================================
	// register addresses (a4 clear)
	localparam logic [ADDR_W-1:0] ADDR_FORMAT = 6'h01;
	localparam logic [ADDR_W-1:0] ADDR_SYNC = 6'h02;
	localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 6'h04;

	// format register fields
	localparam int FMT_BLACK_LSB = 0;
	localparam int FMT_INVERT_BIT = 2;
	localparam int FMT_FORMAT_LSB = 3;
	localparam int FMT_LATENCY_LSB = 5;
	// sync register fields
	localparam int SYN_DETECT_BIT = 0;
	localparam int SYN_POL_BIT = 1;
	localparam int SYN_LAG_LSB = 2;

	localparam logic [DATA_W-1:0] FORMAT_RESET = 8'h00;
	localparam logic [DATA_W-1:0] SYNC_RESET = 8'h00;

	// ==========================================================
	// datapath constants
	localparam int CODE_W = 16;
	localparam int RAW_W = 18;
	localparam int SUM_W = 19;
	localparam logic [CODE_W-1:0] CODE_MAX = 16'hFFFF;
	localparam logic [CODE_W-1:0] BLACK_FULL = 16'hFFFF;
	localparam logic [CODE_W-1:0] BLACK_MID = 16'h7FFF;
	localparam logic [CODE_W-1:0] BLACK_ZERO = 16'h0000;
	localparam logic [1:0] BLACK_SEL_FULL = 2'h2;
	localparam logic [1:0] BLACK_SEL_ZERO = 2'h3;
	localparam logic [1:0] FORMAT_NIBBLE = 2'h3;
	localparam int LAT_DEPTH = 4;

	// input pin indices for the synchroniser bank
	localparam int PIN_SCK = 0;
	localparam int PIN_SDI = 1;
	localparam int PIN_SEN = 2;
	localparam int PIN_PIXEL_SYNC_PULSE = 3;
	localparam int PIN_MCLK = 4;
	localparam int PIN_OEN = 5;
	localparam int PIN_N = 6;

	typedef struct packed {
		logic [1:0] adc_black_level_sel;
		logic output_invert;
		logic [1:0] output_format_sel;
		logic [1:0] output_latency_sel;
		logic sync_edge_detect_en;
		logic sync_edge_polarity;
		logic [2:0] sync_lag_count;
	} afe_cfg_s;

	typedef enum logic [1:0] {
		PH_A,
		PH_B,
		PH_C,
		PH_D
	} afe_phase_e;

endpackage

/* File: rtl/afe_sync_gen.sv */
// sampling strobe generator: pin sync pulse or detected edge with lag
`timescale 1ns/1ps
module afe_sync_gen (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_mclk_rise,
	input wire logic i_pixel_sync_pulse_rise,
	input wire logic i_pixel_sync_pulse_fall,
	input wire logic i_detect_en,
	input wire logic i_polarity,
	input wire logic [2:0] i_lag,
	output logic o_sample
);

	logic armed_q;
	logic [2:0] lag_q;
	logic pend_q;
	logic edge_hit;
	logic int_pulse;

	assign edge_hit = i_detect_en & (i_polarity ? i_pixel_sync_pulse_rise : i_pixel_sync_pulse_fall);

	// ==========================================================
	// lag counter in master clock periods
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			armed_q <= 1'b0;
			lag_q <= 3'h0;
		end else if (edge_hit && i_lag != 3'h0) begin
			armed_q <= 1'b1;
			lag_q <= i_lag;
		end else if (armed_q && i_mclk_rise) begin
			lag_q <= lag_q - 3'h1;
			if (lag_q == 3'h1) begin
				armed_q <= 1'b0;
			end
		end
	end

	assign int_pulse = (edge_hit && i_lag == 3'h0) ||
		(armed_q && i_mclk_rise && lag_q == 3'h1);

	// ==========================================================
	// sample on the first master clock rise after the pulse ends
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pend_q <= 1'b0;
		end else if (i_detect_en ? int_pulse : i_pixel_sync_pulse_fall) begin
			pend_q <= 1'b1;
		end else if (i_mclk_rise) begin
			pend_q <= 1'b0;
		end
	end

	assign o_sample = pend_q & i_mclk_rise;

endmodule

/* File: verif/afe_digital_control_chk.sv */
// checker: port assertions of the digitiser control block
`timescale 1ns/1ps
module afe_digital_control_chk (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_pixel_sync_pulse,
	input wire logic i_serial_latch_strobe,
	input wire logic i_output_enable_n,
	input wire logic [7:0] o_pixel_out_bus,
	input wire logic o_pixel_out_oe,
	input wire logic o_sample_strobe,
	input wire afe_pkg::afe_cfg_s o_cfg
);
	// ====================
	// cycles since the pixel sync pin last moved
	logic [7:0] quiet_q;
	logic pin_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			quiet_q <= 8'h00;
			pin_q <= 1'b0;
		end else begin
			pin_q <= i_pixel_sync_pulse;
			if (pin_q != i_pixel_sync_pulse)
				quiet_q <= 8'h00;
			else if (quiet_q != 8'hFF)
				quiet_q <= quiet_q + 8'h01;
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// ====================
	// assertions
	property p_rst_out;
		$rose(i_rst_b) |-> o_cfg == '0 && o_pixel_out_bus == 8'h00;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not clear");
	property p_oe_off;
		i_output_enable_n [*6] |-> !o_pixel_out_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus driven while disabled");
	property p_oe_on;
		(!i_output_enable_n) [*6] |-> o_pixel_out_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("bus not driven");
	property p_cfg_hold;
		(!i_serial_latch_strobe) [*8] |=> $stable(o_cfg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config moved without latch");
	property p_strb_gap;
		o_sample_strobe |=> (!o_sample_strobe) [*6];
	endproperty
	a_strb_gap: assert property (p_strb_gap) else $error("sample strobes too close");
	property p_bus_hold;
		o_sample_strobe ##2 1'b1 |=> $stable(o_pixel_out_bus[6:0]) [*5];
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("first word not held");
	property p_samp_norm;
		o_sample_strobe && !o_cfg.sync_edge_detect_en |-> quiet_q < 8'h14;
	endproperty
	a_samp_norm: assert property (p_samp_norm) else $error("sample without sync");
	property p_samp_det;
		o_sample_strobe && o_cfg.sync_edge_detect_en |-> quiet_q < 8'h5A;
	endproperty
	a_samp_det: assert property (p_samp_det) else $error("sample without edge");
endmodule

bind afe_digital_control afe_digital_control_chk i_afe_digital_control_chk (
	.i_ref_clk(i_ref_clk),
	.i_rst_b(i_rst_b),
	.i_pixel_sync_pulse(i_pixel_sync_pulse),
	.i_serial_latch_strobe(i_serial_latch_strobe),
	.i_output_enable_n(i_output_enable_n),
	.o_pixel_out_bus(o_pixel_out_bus),
	.o_pixel_out_oe(o_pixel_out_oe),
	.o_sample_strobe(o_sample_strobe),
	.o_cfg(o_cfg)
);

/* File: verif/afe_digital_control_tb_top.sv */
// testbench: serial port, pixel path and sync modes of the digitiser control block
`timescale 1ns/1ps
module afe_digital_control_tb_top;
	// ====================
	// harness
	typedef struct packed {
		logic [1:0] sel;
		logic inv;
		logic [1:0] fmt;
		logic [17:0] raw;
		logic [15:0] code;
	} afe_row_s;
	afe_row_s rows [6] = '{
		'{2'h0, 1'h0, 2'h0, 18'h00123, 16'h8122},
		'{2'h1, 1'h1, 2'h1, 18'h3FFFB, 16'h8005},
		'{2'h2, 1'h0, 2'h2, 18'h3FED4, 16'hFED3},
		'{2'h3, 1'h0, 2'h3, 18'h01234, 16'h1234},
		'{2'h3, 1'h1, 2'h3, 18'h3FFF9, 16'hFFFF},
		'{2'h2, 1'h0, 2'h0, 18'h00005, 16'hFFFF}};
	logic ref_clk;
	logic rst_b;
	logic signed [afe_pkg::RAW_W-1:0] adc_raw;
	logic sck;
	logic serial_in;
	logic serial_latch_strobe;
	logic pixel_sync_pulse;
	logic mclk;
	logic oe_n;
	logic [7:0] bus;
	logic oe;
	logic strb;
	afe_pkg::afe_cfg_s cfg;
	int n_errors = 0;
	int compares = 0;
	int cnt;
	int first;
	int t0;
	logic [7:0] rd;
	logic [7:0] got [4];
	afe_row_s w;

	afe_digital_control i_afe_digital_control (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
		.i_serial_clk(sck), .i_serial_in(serial_in), .i_serial_latch_strobe(serial_latch_strobe),
		.i_pixel_sync_pulse(pixel_sync_pulse), .i_master_clk(mclk), .i_output_enable_n(oe_n),
		.i_adc_raw(adc_raw), .o_pixel_out_bus(bus), .o_pixel_out_oe(oe),
		.o_sample_strobe(strb), .o_cfg(cfg));
	afe_host_model i_afe_host_model (.i_serial_out(bus[7]), .o_serial_clk(sck),
		.o_serial_in(serial_in), .o_serial_latch_strobe(serial_latch_strobe), .o_pixel_sync_pulse(pixel_sync_pulse),
		.o_master_clk(mclk), .o_output_enable_n(oe_n));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic fr(input logic [13:0] f);
		i_afe_host_model.frame(f, rd);
	endtask
	// sample one pixel and collect the four bus phases
	task automatic shot(input logic [17:0] raw);
		int k;
		@(posedge ref_clk);
		#1 adc_raw = raw;
		i_afe_host_model.sync_pulse();
		for (k = 0; k < 100 && strb !== 1'b1; k++)
			@(negedge ref_clk);
		if (k == 100) begin
			n_errors++;
			report_and_stop();
		end
		for (int p = 0; p < 4; p++) begin
			repeat (p == 0 ? 4 : 8) @(negedge ref_clk);
			got[p] = bus;
		end
	endtask
	task automatic edge_cnt(input logic v);
		i_afe_host_model.sync_level(v);
		cnt = 0;
		first = -1;
		for (int k = 0; k < 60; k++) begin
			@(negedge ref_clk);
			if (strb === 1'b1) begin
				if (cnt == 0)
					first = k;
				cnt++;
			end
		end
	endtask
	function automatic logic [7:0] msk(input logic [1:0] f);
		return (f == afe_pkg::FORMAT_NIBBLE) ? 8'hF0 : 8'hFF;
	endfunction
	function automatic logic [7:0] want(input afe_row_s r, input int p);
		if (r.fmt == afe_pkg::FORMAT_NIBBLE)
			return {r.code[15 - 4 * p -: 4], 4'h0};
		return (p == 0) ? r.code[15:8] : r.code[7:0];
	endfunction

	// ====================
	// sequence
	initial begin
		rst_b = 1'b0;
		adc_raw = 18'h00000;
		repeat (10) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		@(negedge ref_clk);
		check({4'h0, cfg}, 16'h0000);
		check({8'h00, bus}, 16'h0000);
		fr({afe_pkg::ADDR_SOFT_RESET, 8'hFF});
		$display("reset test done");
		foreach (rows[r]) begin
			w = rows[r];
			fr({afe_pkg::ADDR_FORMAT, 3'h0, w.fmt, w.inv, w.sel});
			check({4'h0, cfg}, {4'h0, w.sel, w.inv, w.fmt, 7'h00});
			shot(w.raw);
			for (int p = 0; p < 4; p++)
				check({8'h00, got[p] & msk(w.fmt)}, {8'h00, want(w, p)});
			$display("row %0d done", r);
		end
		fr({afe_pkg::ADDR_FORMAT, 8'h6B});
		fr({afe_pkg::ADDR_SYNC, 8'h16});
		fr({afe_pkg::ADDR_FORMAT | 6'h10, 8'hA5});
		fr({afe_pkg::ADDR_SYNC | 6'h10, 8'h5A});
		check({8'h00, rd}, 16'h006B);
		fr({6'h05, 8'hFF});
		check({8'h00, rd}, 16'h0016);
		check({4'h0, cfg}, 16'h0CED);
		fr({6'h13, 8'h00});
		fr({afe_pkg::ADDR_SOFT_RESET, 8'h00});
		check({8'h00, rd}, 16'h0000);
		check({4'h0, cfg}, 16'h0000);
		i_afe_host_model.set_oe_n(1'b1);
		repeat (10) @(negedge ref_clk);
		check({15'h0000, oe}, 16'h0000);
		i_afe_host_model.set_oe_n(1'b0);
		repeat (10) @(negedge ref_clk);
		check({15'h0000, oe}, 16'h0001);
		$display("register test done");
		fr({afe_pkg::ADDR_FORMAT, 8'h43});
		shot(18'h01111);
		shot(18'h02222);
		shot(18'h03333);
		check({got[0], got[1]}, 16'h1111);
		fr({afe_pkg::ADDR_FORMAT, 8'h23});
		shot(18'h04444);
		check({got[0], got[1]}, 16'h3333);
		fr({afe_pkg::ADDR_FORMAT, 8'h63});
		shot(18'h05555);
		check({got[0], got[1]}, 16'h2222);
		$display("latency test done");
		fr({afe_pkg::ADDR_SYNC, 8'h01});
		edge_cnt(1'b1);
		check(16'(cnt), 16'h0000);
		edge_cnt(1'b0);
		check(16'(cnt), 16'h0001);
		t0 = first;
		fr({afe_pkg::ADDR_SYNC, 8'h0B});
		edge_cnt(1'b1);
		check(16'(first - t0), 16'h0010);
		edge_cnt(1'b0);
		check(16'(cnt), 16'h0000);
		$display("sync test done");
		report_and_stop();
	end
endmodule

/* File: verif/afe_host_model.sv */
// partner model: scanner controller driving clocks, pixel sync and serial port
`timescale 1ns/1ps
module afe_host_model (
	input wire logic i_serial_out,
	output logic o_serial_clk,
	output logic o_serial_in,
	output logic o_serial_latch_strobe,
	output logic o_pixel_sync_pulse,
	output logic o_master_clk,
	output logic o_output_enable_n
);
	// ====================
	// pins and free running master clock
	initial begin
		o_serial_clk = 1'b0;
		o_serial_in = 1'b0;
		o_serial_latch_strobe = 1'b0;
		o_pixel_sync_pulse = 1'b0;
		o_output_enable_n = 1'b0;
		o_master_clk = 1'b0;
		#3;
		forever #32 o_master_clk = ~o_master_clk;
	end
	// 14 bits msb first; first 8 read-back bits taken just before each fall
	task automatic frame(input logic [13:0] f, output logic [7:0] rd);
		rd = 8'h00;
		for (int i = 13; i >= 0; i--) begin
			o_serial_in = f[i];
			#16 o_serial_clk = 1'b1;
			#32;
			if (i > 5)
				rd = {rd[6:0], i_serial_out};
			o_serial_clk = 1'b0;
			#16;
		end
		o_serial_in = ~o_serial_in;
		#16 o_serial_latch_strobe = 1'b1;
		#32 o_serial_latch_strobe = 1'b0;
		#48;
	endtask
	task automatic sync_level(input logic v);
		@(posedge o_master_clk);
		// offset keeps the pin change clear of the system clock edge
		#2 o_pixel_sync_pulse = v;
	endtask
	task automatic sync_pulse();
		sync_level(1'b1);
		sync_level(1'b0);
	endtask
	task automatic set_oe_n(input logic v);
		o_output_enable_n = v;
	endtask
endmodule
